/* File: inc/rsc_pkg.sv */
// Purpose: constants shared by the reset source and cause logic
// Assumes: one 200 MHz clock, register port with one-cycle read latency
// Notes:   register index 0 holds the reset cause status byte
package rsc_pkg;
	localparam int          CLK_MHZ          = 200;
	localparam int          ADDR_W           = 4;
	localparam int          DATA_W           = 8;
	localparam logic [3:0]  ADDR_CAUSE       = 4'h0;
	localparam logic [3:0]  ADDR_CTRL        = 4'h1;
	localparam int          BIT_BROWNOUT     = 0;
	localparam int          BIT_POWERON      = 1;
	localparam int          BIT_POWERDOWN    = 2;
	localparam int          BIT_WDT_TIMEOUT  = 3;
	localparam int          BIT_RESET_INSTR  = 4;
	localparam int          BIT_PRIO_EN      = 7;
	localparam logic [7:0]  CAUSE_WMASK      = 8'h93;
	localparam logic [7:0]  CAUSE_RST        = 8'h1c;
	// filter length on the external reset pin, in ns and in clocks
	localparam int          PIN_FILTER_NS    = 200;
	localparam int          PIN_FILTER_CYC   = (PIN_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int          FILT_W           = 6;
	// internal rc period in ns; the rc tick is derived by a divider
	localparam int          RC_PERIOD_NS     = 32000;
	localparam int          RC_DIV_CYC       = (RC_PERIOD_NS * CLK_MHZ) / 1000;
	localparam int          RC_DIV_W         = 13;
	localparam int          POWERUP_TIMER_W           = 11;
	localparam logic [10:0] POWERUP_TIMER_LAST        = 11'h7ff;
	typedef enum logic [1:0] {
		RSC_ST_RESET,
		RSC_ST_TIMER,
		RSC_ST_RUN
	} rsc_state_type;
endpackage : rsc_pkg

/* File: src/rsc_pin_filter.sv */
// Purpose: synchronise and debounce the active-low external reset pin
// Assumes: pin is asynchronous to the clock
// Notes:   output goes low only after the pin has been low for the full filter length
`timescale 1ns/100ps
module rsc_pin_filter (
	// clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rst_n,
	// pin in, filtered level out
	input  wire logic i_pin_n,
	output logic      o_level_n
);
	import rsc_pkg::*;

	logic              sync_a;
	logic              sync_b;
	logic [FILT_W-1:0] low_count;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= i_pin_n;
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_count <= '0;
			o_level_n <= 1'b1;
		end else if (sync_b) begin
			low_count <= '0;
			o_level_n <= 1'b1;
		end else if (low_count >= FILT_W'(PIN_FILTER_CYC - 1)) begin
			o_level_n <= 1'b0;
		end else begin
			low_count <= low_count + FILT_W'(1);
		end
	end
endmodule : rsc_pin_filter

/* File: src/rsc_reset_cause.sv */
// Purpose: reset generation and reset cause capture
// Assumes: supply monitor inputs are synchronous levels
// Notes:   register port: addr, wdata, wr, rd, rdata one cycle later
// Contract
// - pin low holds core in reset
// - short low pin pulses are filtered out
// - no internal source drives pin low
// - supply-good rise raises power-on reset
// - power-on reset clears power-on flag
// - other resets keep power-on flag
// - only software sets power-on flag
// - brown-out works only with regulator enabled
// - regulator low output enters brown-out reset
// - hold reset until regulator output sufficient
// - timer runs full delay after brown-out
// - brown-out during timer restarts the count
// - timer restarts fully when supply returns
// - brown-out flag zero while regulator disabled
// - 11-bit timer counts 2048 rc periods
// - brown-out or power-on clears brown-out flag
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
module rsc_reset_cause (
	// clock and reset
	input  wire logic                       i_ref_clk,
	input  wire logic                       i_rst_n,
	// external reset pin, input only
	input  wire logic                       i_external_reset_pin_n,
	// supply monitors
	input  wire logic                       i_supply_good,
	input  wire logic                       i_regulator_enable_pin,
	input  wire logic                       i_regulator_low,
	input  wire logic                       i_regulator_ok,
	// other reset cause events
	input  wire logic                       i_wdt_timeout,
	input  wire logic                       i_sleep_entry,
	input  wire logic                       i_watchdog_clear_instruction,
	input  wire logic                       i_reset_instruction,
	// register port
	input  wire logic [rsc_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [rsc_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                       i_wr,
	input  wire logic                       i_rd,
	output logic      [rsc_pkg::DATA_W-1:0] o_rdata,
	// reset outputs
	output logic                            o_core_reset,
	output logic                            o_timer_running
);
	import rsc_pkg::*;

	// filtered pin and edge detection
	logic                  pin_level_n;
	logic                  supply_prev;
	logic                  por_event;
	logic                  bor_active;
	logic                  bor_prev;
	logic                  bor_event;
	logic                  any_source;
	// rc clock enable and power-up timer
	logic [RC_DIV_W-1:0]   rc_div;
	logic                  rc_tick;
	logic [POWERUP_TIMER_W-1:0]     powerup_timer;
	// sequencer
	rsc_state_type         state;
	rsc_state_type         next_state;
	// status byte and one flop per cause flag
	logic [DATA_W-1:0]     cause;
	logic                  cause_wr;
	logic                  por_hold;
	logic                  prio_en_flag;
	logic                  reset_instr_flag;
	logic                  timeout_flag;
	logic                  powerdown_flag;
	logic                  poweron_flag;
	logic                  brownout_flag;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
		return a == r;
	endfunction : hit

	// a write touches only the bits that software may write
	function automatic logic soft_write(input logic wr, input int b);
		return wr && CAUSE_WMASK[b];
	endfunction : soft_write

	// pin is only ever sampled here; there is no drive path back to it
	rsc_pin_filter u_filter (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_pin_n   (i_external_reset_pin_n),
		.o_level_n (pin_level_n)
	);

	// power-on event on rising supply-good; brown-out gated by regulator enable
	assign por_event  = i_supply_good && !supply_prev;
	assign bor_active = i_regulator_enable_pin && (i_regulator_low || !i_regulator_ok);
	assign bor_event  = bor_active && !bor_prev;
	assign cause_wr   = i_wr && hit(i_addr, ADDR_CAUSE);
	// any active source keeps the sequencer out of the timer and run states
	assign any_source = por_hold || !i_supply_good || por_event || bor_active;
	// status byte; bits 6 and 5 read as zero
	assign cause      = {prio_en_flag, 2'b00, reset_instr_flag, timeout_flag,
	                     powerdown_flag, poweron_flag, brownout_flag};

	// previous supply-good level for the power-on edge
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			supply_prev <= 1'b0;
		end else begin
			supply_prev <= i_supply_good;
		end
	end

	// previous brown-out level for the brown-out edge
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bor_prev <= 1'b0;
		end else begin
			bor_prev <= bor_active;
		end
	end

	// supply low, seen one cycle late, also covers the first cycle after reset
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			por_hold <= 1'b1;
		end else begin
			por_hold <= !i_supply_good;
		end
	end

	// rc clock rate derived as a one-cycle enable
	// the divider free-runs, so the first timer step comes up to one rc period after entry
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rc_div  <= '0;
			rc_tick <= 1'b0;
		end else if (rc_div == RC_DIV_W'(RC_DIV_CYC - 1)) begin
			rc_div  <= '0;
			rc_tick <= 1'b1;
		end else begin
			rc_div  <= rc_div + RC_DIV_W'(1);
			rc_tick <= 1'b0;
		end
	end

	// sequencer: reset while a source is active, then timer, then run
	always_comb begin
		next_state = state;
		case (state)
			RSC_ST_RESET: begin
				// the pin only gates the core reset and never restarts the timer
				if (!any_source) begin
					next_state = RSC_ST_TIMER;
				end
			end
			RSC_ST_TIMER: begin
				if (any_source) begin
					next_state = RSC_ST_RESET;
				end else if (rc_tick && powerup_timer == POWERUP_TIMER_LAST) begin
					next_state = RSC_ST_RUN;
				end
			end
			RSC_ST_RUN: begin
				if (any_source) begin
					next_state = RSC_ST_RESET;
				end
			end
			default: begin
				next_state = RSC_ST_RESET;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= RSC_ST_RESET;
		end else begin
			state <= next_state;
		end
	end

	// 11-bit power-up timer, counts 2048 rc ticks
	// every other state clears the count, so each entry runs the full delay
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			powerup_timer <= '0;
		end else if (state != RSC_ST_TIMER) begin
			powerup_timer <= '0;
		end else if (rc_tick) begin
			powerup_timer <= powerup_timer + POWERUP_TIMER_W'(1);
		end
	end

	// core reset: filtered pin, power-on, brown-out or running timer
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_core_reset <= 1'b1;
		end else begin
			o_core_reset <= !pin_level_n || next_state != RSC_ST_RUN;
		end
	end

	// timer status, registered like the core reset so both change together
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_timer_running <= 1'b0;
		end else begin
			o_timer_running <= next_state == RSC_ST_TIMER;
		end
	end

	// reset cause flags, one process each
	// a hardware event wins over a software write in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prio_en_flag <= CAUSE_RST[BIT_PRIO_EN];
		end else if (soft_write(cause_wr, BIT_PRIO_EN)) begin
			prio_en_flag <= i_wdata[BIT_PRIO_EN];
		end
	end

	// reset instruction flag: cleared by the instruction, set by power-on or brown-out
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reset_instr_flag <= CAUSE_RST[BIT_RESET_INSTR];
		end else if (por_event || bor_event) begin
			reset_instr_flag <= 1'b1;
		end else if (i_reset_instruction) begin
			reset_instr_flag <= 1'b0;
		end else if (soft_write(cause_wr, BIT_RESET_INSTR)) begin
			reset_instr_flag <= i_wdata[BIT_RESET_INSTR];
		end
	end

	// watchdog timeout flag, read-only: a timeout clears it, the clear instruction sets it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timeout_flag <= CAUSE_RST[BIT_WDT_TIMEOUT];
		end else if (por_event || bor_event) begin
			timeout_flag <= 1'b1;
		end else if (i_wdt_timeout) begin
			timeout_flag <= 1'b0;
		end else if (i_watchdog_clear_instruction) begin
			timeout_flag <= 1'b1;
		end
	end

	// power-down flag, read-only: sleep entry clears it, the clear instruction sets it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			powerdown_flag <= CAUSE_RST[BIT_POWERDOWN];
		end else if (por_event || bor_event) begin
			powerdown_flag <= 1'b1;
		end else if (i_sleep_entry) begin
			powerdown_flag <= 1'b0;
		end else if (i_watchdog_clear_instruction) begin
			powerdown_flag <= 1'b1;
		end
	end

	// power-on flag: a power-on or a software write clears it, only software sets it
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			poweron_flag <= CAUSE_RST[BIT_POWERON];
		end else if (por_event) begin
			poweron_flag <= 1'b0;
		end else if (soft_write(cause_wr, BIT_POWERON)) begin
			poweron_flag <= i_wdata[BIT_POWERON];
		end
	end

	// brown-out flag: held low while the regulator is off, cleared by brown-out or power-on
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			brownout_flag <= CAUSE_RST[BIT_BROWNOUT];
		end else if (!i_regulator_enable_pin) begin
			brownout_flag <= 1'b0;
		end else if (por_event || bor_event) begin
			brownout_flag <= 1'b0;
		end else if (soft_write(cause_wr, BIT_BROWNOUT)) begin
			brownout_flag <= i_wdata[BIT_BROWNOUT];
		end
	end

	// read port, data one cycle after the strobe, zero otherwise
	// the control index shows the registered timer status, the live brown-out level and the filtered pin level
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
		end else if (i_rd && hit(i_addr, ADDR_CAUSE)) begin
			o_rdata <= cause;
		end else if (i_rd && hit(i_addr, ADDR_CTRL)) begin
			o_rdata <= {5'h00, o_timer_running, bor_active, pin_level_n};
		end else begin
			o_rdata <= '0;
		end
	end
endmodule : rsc_reset_cause

/* File: bench/rsc_reset_cause_properties.sv */
// Purpose: port checker for the reset source and cause logic
// Assumes: supply inputs are levels
// Notes:   pin run counters bound the filter delay
`timescale 1ns/100ps
module rsc_reset_cause_properties (
	input wire logic                       i_ref_clk, i_rst_n, i_external_reset_pin_n, i_supply_good,
	input wire logic                       i_regulator_enable_pin, i_regulator_low, i_regulator_ok, i_wr, i_rd,
	input wire logic [rsc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rsc_pkg::DATA_W-1:0] o_rdata,
	input wire logic                       o_core_reset, o_timer_running
);
	import rsc_pkg::*;
	logic [5:0] low_cnt;
	logic [5:0] since_long;
	// consecutive low samples, and cycles since a run long enough to pass the filter
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_cnt    <= 6'h00;
			since_long <= 6'h00;
		end else begin
			low_cnt    <= i_external_reset_pin_n ? 6'h00 : low_cnt + {5'h00, low_cnt != 6'h3f};
			since_long <= (low_cnt >= 6'h26) ? 6'h00 : since_long + {5'h00, since_long != 6'h3f};
		end
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	pin_hold_a: assert property (low_cnt >= 6'h2e |-> o_core_reset) else $error("pin low, no reset");
	glitch_free_a: assert property ((i_rd && i_addr == ADDR_CTRL && since_long > 6'h32) |=> o_rdata[0])
		else $error("short pin pulse passed");
	por_hold_a: assert property (!i_supply_good |=> o_core_reset) else $error("no reset, supply low");
	por_clear_a: assert property ($rose(i_supply_good) ##1 !i_wr ##1 (i_rd && i_addr == ADDR_CAUSE)
		|=> !o_rdata[BIT_POWERON]) else $error("power-on flag not cleared");
	bor_off_a: assert property ((i_rd && i_addr == ADDR_CAUSE && !i_regulator_enable_pin
		&& !$past(i_regulator_enable_pin)) |=> !o_rdata[BIT_BROWNOUT]) else $error("brown-out flag set");
	bor_reset_a: assert property ((i_regulator_enable_pin && i_regulator_low) |=> o_core_reset)
		else $error("no brown-out reset");
	timer_start_a: assert property ((i_supply_good && $past(i_supply_good) && i_regulator_enable_pin
		&& i_regulator_ok && !i_regulator_low && $past(i_regulator_enable_pin && i_regulator_low))
		|=> o_timer_running) else $error("timer idle");
	timer_kill_a: assert property ((o_timer_running && i_regulator_enable_pin && i_regulator_low)
		|=> !o_timer_running && o_core_reset) else $error("timer kept running");
endmodule : rsc_reset_cause_properties
bind rsc_reset_cause rsc_reset_cause_properties i_chk (.*);

/* File: bench/rsc_supply_model.sv */
// Purpose: far side: reset pin driver and supply monitors
// Assumes: pin has a pull-up
// Notes:   a disabled regulator shows a dead output
`timescale 1ns/100ps
module rsc_supply_model (
	input  wire logic i_ref_clk,
	output logic      o_pin_n,
	output logic      o_supply_good,
	output logic      o_reg_en,
	output logic      o_reg_low,
	output logic      o_reg_ok
);
	logic low_q = 1'b0;
	logic ok_q  = 1'b0;
	// a disabled regulator reads as failing, so the enable gating is exercised
	assign o_reg_low = o_reg_en ? low_q : 1'b1;
	assign o_reg_ok  = o_reg_en & ok_q;
	initial begin
		o_pin_n       = 1'b1;
		o_supply_good = 1'b0;
		o_reg_en      = 1'b0;
	end
	// {good, enable, low, ok}
	task automatic supply(input logic [3:0] v);
		@(posedge i_ref_clk);
		{o_supply_good, o_reg_en, low_q, ok_q} <= v;
	endtask : supply
	task automatic pin(input logic lvl);
		@(posedge i_ref_clk);
		o_pin_n <= lvl;
	endtask : pin
endmodule : rsc_supply_model

/* File: bench/rsc_reset_cause_tb.sv */
// Purpose: self-checking bench for the reset source and cause logic
// Assumes: power-up timer too long to expire in this run
// Notes:   watchdog, sleep and instruction events are pulsed one cycle at a time
`timescale 1ns/100ps
module rsc_reset_cause_tb;
	import rsc_pkg::*;
	logic              i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr, i_rd;
	logic              i_wdt_timeout, i_sleep_entry, i_watchdog_clear_instruction, i_reset_instruction;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, o_rdata;
	logic              o_core_reset, o_timer_running, i_external_reset_pin_n, i_supply_good;
	logic              i_regulator_enable_pin, i_regulator_low, i_regulator_ok;
	int                n_fail = 0, num_checks = 0;
	rsc_supply_model i_sup (.i_ref_clk(i_ref_clk), .o_pin_n(i_external_reset_pin_n), .o_supply_good(i_supply_good),
		.o_reg_en(i_regulator_enable_pin), .o_reg_low(i_regulator_low), .o_reg_ok(i_regulator_ok));
	rsc_reset_cause i_dut (.*);
	initial forever #2.5 i_ref_clk = ~i_ref_clk;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		{i_wr, i_addr, i_wdata} <= {1'b1, a, d};
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge i_ref_clk);
		{i_rd, i_addr} <= {1'b1, a};
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1 chk("rdata", e, o_rdata & m);
	endtask : rd
	// {core reset, timer running} after n edges
	task automatic outs(input int n, input logic [1:0] e);
		repeat (n) @(posedge i_ref_clk);
		#1 chk("core reset and timer", {6'h00, e}, {6'h00, o_core_reset, o_timer_running});
	endtask : outs
	task automatic t_power_on;
		outs(2, 2'b10);
		rd(ADDR_CAUSE, 8'hff, 8'h1c);
		i_sup.supply(4'h8);
		wr(ADDR_CAUSE, 8'h13);
		rd(ADDR_CAUSE, 8'hff, 8'h1e);
		wr(ADDR_CAUSE, 8'hff);
		rd(ADDR_CAUSE, 8'hff, 8'h9e);
		wr(4'h5, 8'h00);
		rd(4'h5, 8'hff, 8'h00);
		rd(ADDR_CTRL, 8'h03, 8'h01);
		i_sup.supply(4'h0);
		outs(3, 2'b10);
		i_sup.supply(4'h8);
		@(posedge i_ref_clk);
		rd(ADDR_CAUSE, 8'hff, 8'h9c);
		wr(ADDR_CAUSE, 8'h13);
	endtask : t_power_on
	task automatic t_pin;
		i_sup.pin(1'b0);
		repeat (30) @(posedge i_ref_clk);
		i_sup.pin(1'b1);
		rd(ADDR_CTRL, 8'h01, 8'h01);
		i_sup.pin(1'b0);
		outs(50, 2'b11);
		rd(ADDR_CTRL, 8'h01, 8'h00);
		i_sup.pin(1'b1);
		rd(ADDR_CAUSE, 8'hff, 8'h1e);
	endtask : t_pin
	// {watchdog timeout, sleep entry, clear instruction, reset instruction}, one cycle
	task automatic fire(input logic [3:0] v);
		@(posedge i_ref_clk);
		{i_wdt_timeout, i_sleep_entry, i_watchdog_clear_instruction, i_reset_instruction} <= v;
		@(posedge i_ref_clk);
		{i_wdt_timeout, i_sleep_entry, i_watchdog_clear_instruction, i_reset_instruction} <= 4'h0;
	endtask : fire
	task automatic t_events;
		fire(4'h4);
		rd(ADDR_CAUSE, 8'hff, 8'h1a);
		fire(4'h8);
		rd(ADDR_CAUSE, 8'hff, 8'h12);
		wr(ADDR_CAUSE, 8'h1e);
		rd(ADDR_CAUSE, 8'hff, 8'h12);
		fire(4'h3);
		rd(ADDR_CAUSE, 8'hff, 8'h0e);
		wr(ADDR_CAUSE, 8'h13);
		rd(ADDR_CAUSE, 8'hff, 8'h1e);
	endtask : t_events
	task automatic t_brownout;
		i_sup.supply(4'hd);
		wr(ADDR_CAUSE, 8'h13);
		rd(ADDR_CAUSE, 8'hff, 8'h1f);
		i_sup.supply(4'he);
		outs(2, 2'b10);
		rd(ADDR_CTRL, 8'h06, 8'h02);
		rd(ADDR_CAUSE, 8'hff, 8'h1e);
		i_sup.supply(4'hc);
		outs(4, 2'b10);
		i_sup.supply(4'hd);
		outs(2, 2'b11);
		outs(200, 2'b11);
		i_sup.supply(4'he);
		outs(2, 2'b10);
		i_sup.supply(4'hd);
		outs(2, 2'b11);
	endtask : t_brownout
	task automatic end_of_test;
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	initial begin
		{i_wr, i_rd, i_addr, i_wdata} <= 14'h0000;
		{i_wdt_timeout, i_sleep_entry, i_watchdog_clear_instruction, i_reset_instruction} <= 4'h0;
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		t_power_on;
		t_pin;
		t_events;
		t_brownout;
		end_of_test;
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		n_fail++;
		end_of_test;
	end
endmodule : rsc_reset_cause_tb
